// ---- hdl/code_bank_address_mapper.sv ----
// Contract
// - four 32 kB banks behind 64 kB window
// - lower half always reaches bank 0
// - upper half goes to selected bank
// - fetch field bits 1:0 picks fetch bank
// - constant field bits 5:4 picks data bank
// - fetch field writes only from bank 0
// - reserved bits read zero, written zero
// - register at 0x84 on every page
// - top flash byte is lock byte
// - small parts map flash directly
`timescale 1ns/1ps
`default_nettype none
module code_bank_address_mapper #(
	parameter int flash_bytes = 131072
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// special-register port from the core
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic exec_in_bank0,
	output logic [7:0] sfr_rdata,
	output logic sfr_hit,
	// fetch path
	input wire bank_map_pkg::access_s fetch_req,
	output bank_map_pkg::flash_s fetch_out,
	// constant read and flash write path
	input wire bank_map_pkg::access_s const_req,
	output bank_map_pkg::flash_s const_out,
	// current field values
	output logic [1:0] fetch_bank,
	output logic [1:0] const_bank
);
	logic sel_match;
	logic [1:0] next_fetch_bank;
	logic [1:0] next_const_bank;
	logic [7:0] next_sfr_rdata;
	logic next_sfr_hit;
	bank_map_pkg::flash_s fetch_map;
	bank_map_pkg::flash_s const_map;
	// small parts map flash directly
	localparam bit banked = flash_bytes > bank_map_pkg::flash_64k;
	// lock byte location for this size, for the checks
	localparam logic [16:0] top_loc =
		(flash_bytes >= bank_map_pkg::flash_128k) ?
		bank_map_pkg::lock_128k :
		(flash_bytes >= bank_map_pkg::flash_64k) ?
		bank_map_pkg::lock_64k :
		(flash_bytes >= bank_map_pkg::flash_32k) ?
		bank_map_pkg::lock_32k :
		bank_map_pkg::lock_16k;

	// decode ignores paging entirely
	assign sel_match = (sfr_addr == bank_map_pkg::sel_addr);

	// field updates; fetch field only from bank 0 code
	always_comb begin
		next_fetch_bank = fetch_bank;
		next_const_bank = const_bank;
		if (sfr_wr && sel_match) begin
			next_const_bank = sfr_wdata[bank_map_pkg::const_lsb +: 2];
			if (exec_in_bank0) begin
				next_fetch_bank = sfr_wdata[bank_map_pkg::fetch_lsb +: 2];
			end
		end
	end

	// field write checks
	chk_fetch_write: assert property (
		@(posedge clk) disable iff (!rst_b)
		sfr_wr && sel_match && exec_in_bank0 |=>
		fetch_bank == $past(sfr_wdata[1:0]))
		else $error("fetch field not written");
	chk_fetch_guard: assert property (
		@(posedge clk) disable iff (!rst_b)
		sfr_wr && !exec_in_bank0 |=>
		$stable(fetch_bank))
		else $error("fetch field changed outside bank 0");
	chk_const_write: assert property (
		@(posedge clk) disable iff (!rst_b)
		sfr_wr && sel_match |=>
		const_bank == $past(sfr_wdata[5:4]))
		else $error("constant field not written");
	chk_miss_hold: assert property (
		@(posedge clk) disable iff (!rst_b)
		!(sfr_wr && sel_match) |=>
		$stable(fetch_bank) && $stable(const_bank))
		else $error("field changed without a register write");

	// read data; reserved bits stay zero
	always_comb begin
		next_sfr_rdata = 8'h00;
		next_sfr_hit = sfr_rd && sel_match;
		if (sfr_rd && sel_match) begin
			next_sfr_rdata[bank_map_pkg::fetch_lsb +: 2] = fetch_bank;
			next_sfr_rdata[bank_map_pkg::const_lsb +: 2] = const_bank;
		end
	end

	// read port checks; a read beside a write returns the old value
	chk_reserved_zero: assert property (
		@(posedge clk) disable iff (!rst_b)
		(sfr_rdata & ~bank_map_pkg::sel_write_mask) == 8'h00)
		else $error("reserved bits read nonzero");
	chk_read_hit: assert property (
		@(posedge clk) disable iff (!rst_b)
		sfr_rd && sel_match |=>
		sfr_hit && sfr_rdata ==
		{2'h0, $past(const_bank), 2'h0, $past(fetch_bank)})
		else $error("register read wrong");
	chk_idle_read: assert property (
		@(posedge clk) disable iff (!rst_b)
		!(sfr_rd && sel_match) |=>
		!sfr_hit && sfr_rdata == 8'h00)
		else $error("read data without a register read");

	// register state
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fetch_bank <= bank_map_pkg::sel_reset[1:0];
			const_bank <= bank_map_pkg::sel_reset[5:4];
			sfr_rdata <= 8'h00;
			sfr_hit <= 1'b0;
			fetch_out <= '0;
			const_out <= '0;
		end else begin
			fetch_bank <= next_fetch_bank;
			const_bank <= next_const_bank;
			sfr_rdata <= next_sfr_rdata;
			sfr_hit <= next_sfr_hit;
			fetch_out <= fetch_map;
			const_out <= const_map;
		end
	end

	// fetch translation uses committed fetch field
	bank_translate #(.flash_bytes(flash_bytes)) u_fetch (
		.req(fetch_req),
		.bank(fetch_bank),
		.res(fetch_map)
	);

	// constant translation uses constant field
	bank_translate #(.flash_bytes(flash_bytes)) u_const (
		.req(const_req),
		.bank(const_bank),
		.res(const_map)
	);

	// bank routing on the registered outputs
	chk_lower_bank0: assert property (
		@(posedge clk) disable iff (!rst_b)
		fetch_req.valid && !fetch_req.addr[15] |=>
		fetch_out.addr[16:15] == 2'h0)
		else $error("lower half fetch left bank 0");
	chk_lower_const: assert property (
		@(posedge clk) disable iff (!rst_b)
		const_req.valid && !const_req.addr[15] |=>
		const_out.addr[16:15] == 2'h0)
		else $error("lower half constant access left bank 0");
	chk_upper_fetch: assert property (
		@(posedge clk) disable iff (!rst_b)
		banked && fetch_req.valid && fetch_req.addr[15] |=>
		fetch_out.addr[16:15] == $past(fetch_bank))
		else $error("upper fetch bank wrong");
	chk_upper_const: assert property (
		@(posedge clk) disable iff (!rst_b)
		banked && const_req.valid && const_req.addr[15] |=>
		const_out.addr[16:15] == $past(const_bank))
		else $error("upper constant bank wrong");
	chk_direct_map: assert property (
		@(posedge clk) disable iff (!rst_b)
		!banked && fetch_req.valid |=>
		fetch_out.addr == {1'b0, $past(fetch_req.addr)})
		else $error("small part fetch not mapped directly");
	chk_valid_follow: assert property (
		@(posedge clk) disable iff (!rst_b)
		1'b1 |=> fetch_out.valid == $past(fetch_req.valid) &&
		const_out.valid == $past(const_req.valid))
		else $error("mapped valid does not follow request");
	// offset within a bank is kept
	chk_fetch_offset: assert property (
		@(posedge clk) disable iff (!rst_b)
		fetch_req.valid |=>
		fetch_out.addr[14:0] == $past(fetch_req.addr[14:0]))
		else $error("fetch offset changed");
	chk_const_offset: assert property (
		@(posedge clk) disable iff (!rst_b)
		const_req.valid |=>
		const_out.addr[14:0] == $past(const_req.addr[14:0]))
		else $error("constant offset changed");
	// lock byte flags
	chk_lock_flag: assert property (
		@(posedge clk) disable iff (!rst_b)
		const_out.lock |-> !const_out.reserved)
		else $error("lock byte marked reserved");
	chk_lock_place: assert property (
		@(posedge clk) disable iff (!rst_b)
		fetch_out.valid |->
		fetch_out.lock == (fetch_out.addr == top_loc) &&
		fetch_out.reserved == (fetch_out.addr > top_loc))
		else $error("lock byte flags wrong");
	// switch timing
	chk_new_fetch: assert property (
		@(posedge clk) disable iff (!rst_b)
		banked && sfr_wr && sel_match && exec_in_bank0 ##1
		fetch_req.valid && fetch_req.addr[15] |=>
		fetch_out.addr[16:15] == $past(sfr_wdata[1:0], 2))
		else $error("new fetch bank not used");
	chk_new_const: assert property (
		@(posedge clk) disable iff (!rst_b)
		banked && sfr_wr && sel_match ##1
		const_req.valid && const_req.addr[15] |=>
		const_out.addr[16:15] == $past(sfr_wdata[5:4], 2))
		else $error("new constant bank not used");
endmodule
`default_nettype wire

// ---- hdl/bank_map_pkg.sv ----
`default_nettype none
package bank_map_pkg;
	// special-register address of the bank select register
	localparam logic [7:0] sel_addr = 8'h84;
	localparam logic [7:0] sel_reset = 8'h00;
	localparam logic [7:0] sel_write_mask = 8'h33;
	// field positions
	localparam int fetch_lsb = 0;
	localparam int const_lsb = 4;
	localparam int upper_bit = 15;
	localparam int bank_w = 2;
	localparam int phys_w = 17;
	// lock byte location per flash size
	localparam logic [16:0] lock_128k = 17'h1FFFF;
	localparam logic [16:0] lock_64k = 17'h0FFFF;
	localparam logic [16:0] lock_32k = 17'h07FFF;
	localparam logic [16:0] lock_16k = 17'h03FFF;
	localparam int flash_128k = 131072;
	localparam int flash_64k = 65536;
	localparam int flash_32k = 32768;

	// one flash access request
	typedef struct packed {
		logic valid;
		logic [15:0] addr;
	} access_s;

	// mapped flash access
	typedef struct packed {
		logic valid;
		logic [16:0] addr;
		logic lock;
		logic reserved;
	} flash_s;
endpackage
`default_nettype wire

// ---- hdl/bank_translate.sv ----
`timescale 1ns/1ps
`default_nettype none
module bank_translate #(
	parameter int flash_bytes = 131072
) (
	// logical request and selected bank
	input wire bank_map_pkg::access_s req,
	input wire logic [1:0] bank,
	// mapped result
	output bank_map_pkg::flash_s res
);
	logic [16:0] lock_loc;

	// lock byte location for this size
	always_comb begin
		if (flash_bytes >= bank_map_pkg::flash_128k) begin
			lock_loc = bank_map_pkg::lock_128k;
		end else if (flash_bytes >= bank_map_pkg::flash_64k) begin
			lock_loc = bank_map_pkg::lock_64k;
		end else if (flash_bytes >= bank_map_pkg::flash_32k) begin
			lock_loc = bank_map_pkg::lock_32k;
		end else begin
			lock_loc = bank_map_pkg::lock_16k;
		end
	end

	// lower half always bank 0, upper half the selected bank;
	// parts of 64 kB or less map straight through, no switching
	always_comb begin
		res.valid = req.valid;
		if (flash_bytes <= bank_map_pkg::flash_64k) begin
			res.addr = {1'b0, req.addr};
		end else if (!req.addr[bank_map_pkg::upper_bit]) begin
			res.addr = {2'h0, req.addr[14:0]};
		end else begin
			res.addr = {bank, req.addr[14:0]};
		end
		res.lock = (res.addr == lock_loc);
		res.reserved = (res.addr > lock_loc);
	end
endmodule
`default_nettype wire

// ---- verif/core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module core_model (
	// clock
	input wire logic clk,
	// requests toward the mapper
	output bank_map_pkg::access_s fetch_req,
	output bank_map_pkg::access_s const_req
);
	integer seed = 32'hE61D;
	logic top;
	// new requests after each falling edge; one in eight aims at the
	// top location so that the lock flag is reached
	initial begin
		fetch_req = '0;
		const_req = '0;
		forever begin
			@(negedge clk);
			top = ($random(seed) % 8 == 0);
			fetch_req = top ? bank_map_pkg::access_s'(17'h1FFFF) :
				bank_map_pkg::access_s'(17'($random(seed)));
			const_req = top ? bank_map_pkg::access_s'(17'h1FFFF) :
				bank_map_pkg::access_s'(17'($random(seed)));
		end
	end
endmodule
`default_nettype wire

// ---- verif/test_code_bank_address_mapper.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_code_bank_address_mapper;
	logic clk, rst_b, sfr_wr, sfr_rd, exec_in_bank0, sfr_hit, e_h;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, e_rd;
	logic [1:0] fetch_bank, const_bank, fb, cb;
	bank_map_pkg::access_s fetch_req, const_req;
	bank_map_pkg::flash_s fetch_out, const_out, e_f, e_c;
	bank_map_pkg::flash_s fetch_out_s, const_out_s, e_fs, e_cs;
	integer fails = 0;
	integer tests_run = 0;
	integer seed = 32'hE61D;
	code_bank_address_mapper code_bank_address_mapper_i (.clk(clk),
		.rst_b(rst_b), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
		.exec_in_bank0(exec_in_bank0), .sfr_rdata(sfr_rdata),
		.sfr_hit(sfr_hit), .fetch_req(fetch_req), .fetch_out(fetch_out),
		.const_req(const_req), .const_out(const_out),
		.fetch_bank(fetch_bank), .const_bank(const_bank));
	core_model core_model_i (.clk(clk), .fetch_req(fetch_req),
		.const_req(const_req));
	// 64 kB part on the same bus, kept to its legal banks
	code_bank_address_mapper #(.flash_bytes(bank_map_pkg::flash_64k))
		small_code_bank_address_mapper_i (.clk(clk), .rst_b(rst_b),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata & 8'h11),
		.exec_in_bank0(exec_in_bank0), .sfr_rdata(), .sfr_hit(),
		.fetch_req(fetch_req), .fetch_out(fetch_out_s),
		.const_req(const_req), .const_out(const_out_s),
		.fetch_bank(), .const_bank());
	// clock and watchdog
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	initial begin
		#300000;
		fails++;
		conclude();
	end
	// expected mapping of one request
	function automatic bank_map_pkg::flash_s map(
		bank_map_pkg::access_s r, logic [1:0] b, bit big);
		logic [16:0] a;
		logic [16:0] l;
		if (!big)
			a = {1'b0, r.addr};
		else if (r.addr[15])
			a = {b, r.addr[14:0]};
		else
			a = {2'b00, r.addr[14:0]};
		l = big ? bank_map_pkg::lock_128k : bank_map_pkg::lock_64k;
		map = '{r.valid, a, a == l, a > l};
	endfunction
	task automatic check(logic [31:0] s, logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	// address fields only matter when valid
	task automatic cmp_map(bank_map_pkg::flash_s s, bank_map_pkg::flash_s e);
		check(e.valid ? 20'(s) : 20'(s.valid), e.valid ? 20'(e) : 20'(e.valid));
	endtask
	task automatic conclude;
		$display("compares %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// one cycle: model update at the edge, compares and stimulus after
	task automatic step;
		@(posedge clk);
		e_f = map(fetch_req, fb, 1'b1);
		e_c = map(const_req, cb, 1'b1);
		e_fs = map(fetch_req, 2'h0, 1'b0);
		e_cs = map(const_req, 2'h0, 1'b0);
		e_h = sfr_rd && sfr_addr == 8'h84;
		e_rd = e_h ? {2'b00, cb, 2'b00, fb} : 8'h00;
		if (sfr_wr && sfr_addr == 8'h84) begin
			cb = sfr_wdata[5:4];
			if (exec_in_bank0)
				fb = sfr_wdata[1:0];
		end
		@(negedge clk);
		cmp_map(fetch_out, e_f);
		cmp_map(const_out, e_c);
		cmp_map(fetch_out_s, e_fs);
		cmp_map(const_out_s, e_cs);
		check(sfr_rdata, e_rd);
		check(sfr_hit, e_h);
		check(fetch_bank, fb);
		check(const_bank, cb);
		sfr_wr = 1'($random(seed));
		sfr_rd = 1'($random(seed));
		exec_in_bank0 = 1'($random(seed));
		sfr_wdata = 8'($random(seed)) & bank_map_pkg::sel_write_mask;
		sfr_addr = $random(seed) % 2 ? 8'h84 : 8'($random(seed));
	endtask
	// random register traffic beside random requests, reset in mid-run
	initial begin
		{rst_b, sfr_wr, sfr_rd, exec_in_bank0, sfr_addr, sfr_wdata} = '0;
		fb = 2'h0;
		cb = 2'h0;
		repeat (16) @(negedge clk);
		rst_b = 1;
		repeat (1000) step();
		$display("random mapping test done");
		rst_b = 0;
		@(negedge clk);
		check(fetch_bank, 2'h0);
		check(const_bank, 2'h0);
		check(20'(fetch_out), 20'h0);
		check({sfr_hit, sfr_rdata}, 9'h0);
		fb = 2'h0;
		cb = 2'h0;
		@(negedge clk);
		rst_b = 1;
		repeat (1000) step();
		$display("reset and restart test done");
		conclude();
	end
endmodule
`default_nettype wire
